// ### fmrx_rx_buffer.sv
// receive status, receive RAM port, code monitor and clock setup regs
`include "fmrx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fmrx_rx_buffer #(
  parameter int RAM_BYTES = `FMRX_RAM_BYTES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // receiver datapath
  input wire logic i_block_start,
  input wire fmrx_pkg::fmrx_block_type i_block,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_irq_event,
  input wire fmrx_pkg::fmrx_method_type i_method,
  // clock regeneration
  input wire logic i_edge_in_gate,
  output logic signed [6:0] o_phase_offset,
  output logic [1:0] o_gate_sel,
  output logic o_use_inside_const
);
  import fmrx_pkg::*;

  localparam int AW = $clog2(RAM_BYTES + 1);
  localparam logic [AW-1:0] LAST = AW'(RAM_BYTES - 1);
  localparam logic [AW-1:0] DEPTH = AW'(RAM_BYTES);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  fmrx_bus_type bus_q;
  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [5:0] idx;
  logic hit;

  assign setup = i_psel & ~i_penable;
  assign done = i_psel & i_penable & o_pready;
  assign wr_done = done & i_pwrite;
  assign rd_done = done & ~i_pwrite;
  assign idx = i_paddr[7:2];

  // a transfer ends at the edge where pready is already high, so writes
  // and pointer moves use done, never the setup cycle; this keeps a held
  // request from acting twice

  // word aligned map, each index one word
  always_comb begin
    hit = 1'b0;
    if (i_paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == 6'(`FMRX_IDX_STATUS)) begin
      hit = ~i_pwrite;
    end else if (idx == 6'(`FMRX_IDX_RAM)) begin
      hit = ~i_pwrite;
    end else if (idx == 6'(`FMRX_IDX_ACCUM)) begin
      hit = i_pwrite;
    end else if (idx == 6'(`FMRX_IDX_CODE)) begin
      hit = ~i_pwrite;
    end else if (idx == 6'(`FMRX_IDX_PHASE)) begin
      hit = 1'b1;
    end else if (idx == 6'(`FMRX_IDX_GATE)) begin
      hit = 1'b1;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic accum_q;
  logic [6:0] phase_q;
  logic [3:0] gate_q;

  // storage condition; value kept, any write also clears address
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      accum_q <= 1'b0;
    end else if (i_ce && wr_done && hit && idx == 6'(`FMRX_IDX_ACCUM)) begin
      accum_q <= i_pwdata[`FMRX_ACCUM_BIT];
    end
  end

  // fixed phase setup
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_q <= `FMRX_PHASE_RST;
    end else if (i_ce && wr_done && hit && idx == 6'(`FMRX_IDX_PHASE)) begin
      phase_q <= i_pwdata[6:0];
    end
  end

  // bit gate setup
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gate_q <= `FMRX_GATE_RST;
    end else if (i_ce && wr_done && hit && idx == 6'(`FMRX_IDX_GATE)) begin
      gate_q <= i_pwdata[3:0];
    end
  end

  // ----------------------------------------
  // status of the block in the RAM
  // ----------------------------------------
  logic [7:0] status_q;
  logic [2:0] code_q;
  logic [1:0] group;
  logic change;
  logic [8:0] n;

  assign n = i_block.number;

  // group boundaries depend on method and A variant
  always_comb begin
    group = 2'b00;
    change = 1'b0;
    if (i_method.method_a) begin
      if (n >= `FMRX_A_G3) begin
        group = 2'b11;
      end else if (n >= `FMRX_A_G2) begin
        group = 2'b10;
      end else if (n >= `FMRX_A_G1) begin
        group = 2'b01;
      end
      change = (n == 9'd1) || (n == `FMRX_A_G1) ||
               (n == `FMRX_A_G2) || (n == `FMRX_A_G3);
      if (!i_method.variant_a1 && n > `FMRX_A0_LAST) begin
        group = 2'b11;
      end
    end else begin
      if (n >= `FMRX_B_G3) begin
        group = 2'b11;
      end else if (n >= `FMRX_B_G2) begin
        group = 2'b10;
      end else if (n >= `FMRX_B_G1) begin
        group = 2'b01;
      end
      change = (n == 9'd1) || (n == `FMRX_B_G1) ||
               (n == `FMRX_B_G2) || (n == `FMRX_B_G3);
    end
  end

  // stored-block gate on the sync state of the new block
  logic store_ok;
  assign store_ok = accum_q ? (i_block.block_sync | i_block.frame_sync)
                            : i_block.frame_sync;

  // status and RAM describe the same block: both move only on a stored
  // block start, so a refused block leaves the last good one readable
  // latch status when a stored block begins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      status_q <= 8'h00;
    end else if (i_ce && i_block_start && store_ok) begin
      status_q[0] <= change;
      status_q[2:1] <= group;
      status_q[3] <= i_block.block_sync;
      status_q[4] <= i_block.frame_sync & i_block.parity;
      status_q[5] <= i_block.frame_sync;
      status_q[6] <= i_block.crc_err;
      status_q[7] <= i_block.frame_sync & i_method.frame_type_a &
                     i_block.real_blk;
    end
  end

  // the monitor tracks every block start, stored or not, so software can
  // watch code detection even while storage is held off
  // identification code monitor
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      code_q <= 3'h0;
    end else if (i_ce && i_block_start) begin
      code_q <= {i_block.code_found, i_block.code};
    end
  end

  // ----------------------------------------
  // receive RAM
  // ----------------------------------------
  logic [7:0] ram [RAM_BYTES];
  logic [AW-1:0] wr_ptr_q;
  logic filling_q;
  logic [AW-1:0] rd_ptr_q;
  logic clr_rd;

  // filling window opens on a stored block, bytes past 34 dropped
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      filling_q <= 1'b0;
    end else if (i_ce && i_block_start) begin
      filling_q <= store_ok;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr_q <= '0;
    end else if (i_ce && i_block_start) begin
      wr_ptr_q <= '0;
    end else if (i_ce && i_byte_valid && filling_q && wr_ptr_q < DEPTH) begin
      wr_ptr_q <= wr_ptr_q + AW'(1);
    end
  end

  // no reset on the array: contents undefined until filled
  always_ff @(posedge i_clk) begin
    if (i_ce && i_byte_valid && filling_q && wr_ptr_q < DEPTH) begin
      ram[wr_ptr_q] <= i_byte;
    end
  end

  // clear has priority over advance in the same cycle
  assign clr_rd = i_irq_event |
                  (wr_done && hit && idx == 6'(`FMRX_IDX_ACCUM));

  // the pointer parks on the last byte instead of wrapping: an over-read
  // returns the final byte again rather than byte 0 of a stale pass
  // read strobe is completion of a RAM port read
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_ptr_q <= '0;
    end else if (i_ce && clr_rd) begin
      rd_ptr_q <= '0;
    end else if (i_ce && rd_done && hit && idx == 6'(`FMRX_IDX_RAM)) begin
      if (rd_ptr_q != LAST) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
    end
  end

  // ----------------------------------------
  // apb answer, one wait-free access phase
  // ----------------------------------------
  logic [7:0] rd_byte;

  // read mux; write-only registers read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (idx == 6'(`FMRX_IDX_STATUS)) begin
      rd_byte = status_q;
    end else if (idx == 6'(`FMRX_IDX_RAM)) begin
      rd_byte = ram[rd_ptr_q];
    end else if (idx == 6'(`FMRX_IDX_CODE)) begin
      rd_byte = {5'h00, code_q};
    end
  end

  // pready rises in the access phase after setup
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus_q <= FMRX_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_ce) begin
      case (bus_q)
        FMRX_IDLE: begin
          if (setup) begin
            bus_q <= FMRX_ANSWER;
            o_pready <= 1'b1;
            o_pslverr <= ~hit;
            o_prdata <= (hit && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
          end
        end
        FMRX_ANSWER: begin
          bus_q <= FMRX_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
          o_prdata <= 32'h0000_0000;
        end
        default: begin
          bus_q <= FMRX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // clock regeneration controls
  // ----------------------------------------
  logic [2:0] fine;
  logic [2:0] coarse;
  logic signed [6:0] net;

  // inhibited codes saturate at four steps to keep the range bounded
  assign fine = (phase_q[2:0] > `FMRX_STEP_MAX) ? `FMRX_STEP_MAX
                                                : phase_q[2:0];
  assign coarse = (phase_q[5:3] > `FMRX_STEP_MAX) ? `FMRX_STEP_MAX
                                                  : phase_q[5:3];

  // full lead is 25 fine steps and one coarse step is 5 fine steps, so
  // the net value spans 25 down to -24 and fits a 7-bit signed word
  // offset in 1/125 units, positive means lead
  always_comb begin
    net = 7'sd0;
    if (phase_q[6]) begin
      net = `FMRX_LEAD_STEPS;
    end
    net = net - 7'(`FMRX_COARSE_STEPS * $signed({4'h0, coarse}))
              - $signed({4'h0, fine});
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_phase_offset <= 7'sd0;
    end else if (i_ce) begin
      o_phase_offset <= net;
    end
  end

  // the gate follows the stored block's sync bit, one edge late; the
  // phase loop sees a stable code for the whole block
  // gate width picked by block sync state of the last stored block
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_gate_sel <= 2'b00;
    end else if (i_ce) begin
      o_gate_sel <= status_q[3] ? gate_q[3:2] : gate_q[1:0];
    end
  end

  // which integration constant the phase loop applies
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_use_inside_const <= 1'b0;
    end else if (i_ce) begin
      o_use_inside_const <= i_edge_in_gate & (o_gate_sel != 2'b00);
    end
  end

endmodule // fmrx_rx_buffer
`default_nettype wire

// ### fmrx_regs.svh
// register map, field positions, reset values and rule summary
//
// What this block does
// - frame-number-change flag on group-start blocks
// - status bits 2:1 report block group
// - method A last group ends 272/284; code keeps reporting group 3 past both
// - status bit 3 shows block sync
// - status bit 4 marks parity block
// - status bit 5 shows frame sync
// - status bit 6 flags CRC error
// - status bit 7 marks REAL block in frame type A only
// - 34-byte receive RAM behind read port
// - interrupt clears RAM read address
// - read strobe advances RAM address
// - any accumulation write clears address
// - accumulation bit 1 picks storage condition
// - code monitor: detect bit, code bits
// - fixed phase shifts sampling clock phase
// - bits 2:0 fine delay 0-4 steps
// - bits 5:3 coarse delay 0-4 steps
// - bit 6 advances phase by 1/5
// - bit gate window around clock edge
// - gate fields before/after block sync
// - inside/outside gate integration select
`ifndef FMRX_REGS_SVH
`define FMRX_REGS_SVH

// ----------------------------------------
// register indices, byte address is 4x
// ----------------------------------------
`define FMRX_IDX_STATUS 4'h2
`define FMRX_IDX_RAM 4'h3
`define FMRX_IDX_ACCUM 4'h4
`define FMRX_IDX_CODE 4'h7
`define FMRX_IDX_PHASE 4'h8
`define FMRX_IDX_GATE 4'h9

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FMRX_ACCUM_BIT 1
`define FMRX_PHASE_RST 7'h00
`define FMRX_GATE_RST 4'h0
`define FMRX_RAM_BYTES 34
`define FMRX_STEP_MAX 3'h4
`define FMRX_LEAD_STEPS 7'sd25
`define FMRX_COARSE_STEPS 7'sd5

// ----------------------------------------
// block group boundaries
// ----------------------------------------
`define FMRX_B_G1 9'd14
`define FMRX_B_G2 9'd137
`define FMRX_B_G3 9'd150
`define FMRX_A_G1 9'd61
`define FMRX_A_G2 9'd131
`define FMRX_A_G3 9'd191
`define FMRX_A0_LAST 9'd272
`define FMRX_A1_LAST 9'd284

`endif

// ### fmrx_pkg.sv
// types shared by the receive register bank
`default_nettype none
package fmrx_pkg;

  // facts about one received block
  typedef struct packed {
    logic [8:0] number;
    logic frame_sync;
    logic block_sync;
    logic parity;
    logic crc_err;
    logic real_blk;
    logic code_found;
    logic [1:0] code;
  } fmrx_block_type;

  // frame method selection
  typedef struct packed {
    logic method_a;
    logic variant_a1;
    logic frame_type_a;
  } fmrx_method_type;

  // bus slave phase
  typedef enum logic [1:0] {
    FMRX_IDLE,
    FMRX_ANSWER
  } fmrx_bus_type;

endpackage
`default_nettype wire

// ### fmrx_host.sv
// host model that drives the apb register port
`timescale 1ns/1ps
`default_nettype none
module fmrx_host (
  // clock
  input wire logic i_clk,
  // apb master side
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr
);
  // idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end
  // one transfer, held until pready is seen; bounded so a hang is reported
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e, output logic to);
    int n;
    n = 0;
    to = 1'b1;
    r = 32'h0000_0000;
    e = 1'b0;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    while (n < 16 && to) begin
      @(posedge i_clk);
      n++;
      if (i_pready) begin
        to = 1'b0;
        r = i_prdata;
        e = i_pslverr;
      end
    end
    // released lines show the inverse, never the stale request
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwrite <= ~w;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule // fmrx_host
`default_nettype wire

// ### fmrx_rx_buffer_sva.sv
// port assertions for the receive register bank
`timescale 1ns/1ps
`default_nettype none
module fmrx_rx_buffer_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // clock regeneration
  input wire logic i_edge_in_gate,
  input wire logic signed [6:0] o_phase_offset,
  input wire logic o_use_inside_const
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // setup phases of interest
  sequence s_setup;
    i_psel && !i_penable && i_ce;
  endsequence
  sequence s_ram_wr;
    s_setup ##0 (i_pwrite && i_paddr == 8'h0c);
  endsequence
  sequence s_accum_rd;
    s_setup ##0 (!i_pwrite && i_paddr == 8'h10);
  endsequence
  a_ready_next: assert property (s_setup |=> o_pready)
    else $error("no ready after setup");
  a_ready_once: assert property (o_pready && i_ce |=> !o_pready)
    else $error("ready held too long");
  a_idle_data: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_byte_wide: assert property (o_pready |-> o_prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_ram_ro: assert property (s_ram_wr |=> o_pready && o_pslverr)
    else $error("ram port write accepted");
  a_accum_wo: assert property (s_accum_rd |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("accum read accepted");
  a_phase_range: assert property (o_phase_offset >= -7'sd24 && o_phase_offset <= 7'sd25)
    else $error("phase offset out of range");
  a_outside_const: assert property (!i_edge_in_gate && i_ce |=> !o_use_inside_const)
    else $error("inside constant while outside gate");
endmodule // fmrx_rx_buffer_sva
bind fmrx_rx_buffer fmrx_rx_buffer_sva u_sva (.i_clk, .i_reset, .i_ce, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_prdata, .o_pslverr,
  .i_edge_in_gate, .o_phase_offset, .o_use_inside_const);
`default_nettype wire

// ### test_fmrx_rx_buffer.sv
// self-checking bench for the receive register bank
`timescale 1ns/1ps
`default_nettype none
module test_fmrx_rx_buffer;
  import fmrx_pkg::*;
  logic i_clk, i_reset, i_ce, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic i_block_start, i_byte_valid, i_irq_event, i_edge_in_gate, o_use_inside_const;
  logic [7:0] i_paddr, i_byte;
  logic [31:0] i_pwdata, o_prdata, rdat;
  logic signed [6:0] o_phase_offset;
  logic [1:0] o_gate_sel;
  fmrx_block_type i_block;
  fmrx_method_type i_method;
  logic err, tmo;
  int mismatches = 0;
  int n_checks = 0;
  // design and host model
  fmrx_rx_buffer uut (.i_clk, .i_reset, .i_ce, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_block_start, .i_block,
    .i_byte_valid, .i_byte, .i_irq_event, .i_method, .i_edge_in_gate, .o_phase_offset,
    .o_gate_sel, .o_use_inside_const);
  fmrx_host host (.i_clk, .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
    .o_paddr(i_paddr), .o_pwdata(i_pwdata), .i_pready(o_pready), .i_prdata(o_prdata),
    .i_pslverr(o_pslverr));
  // 100 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic e_exp);
    host.xfer(w, a, d, rdat, err, tmo);
    if (tmo) begin
      mismatches++;
      stop_test();
    end
    check({err, 32'h0000_0000}, {e_exp, 32'h0000_0000});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 1'b0);
    check({1'b0, rdat}, {1'b0, exp});
  endtask
  task automatic put_block(input logic [8:0] n, input logic [7:0] f, input int nb);
    @(posedge i_clk);
    i_block_start <= 1'b1;
    i_block <= {n, f};
    for (int k = 0; k < nb; k++) begin
      @(posedge i_clk);
      i_block_start <= 1'b0;
      i_byte_valid <= 1'b1;
      i_byte <= 8'ha5 ^ k[7:0];
    end
    @(posedge i_clk);
    i_block_start <= 1'b0;
    i_byte_valid <= 1'b0;
  endtask
  task automatic wait_out;
    repeat (3) @(posedge i_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(8'h08, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    check({26'h000_0000, o_phase_offset}, 33'h0_0000_0000);
  endtask
  task automatic t_refuse;
    bus(1'b0, 8'h00, 32'h0000_0000, 1'b1);
    bus(1'b0, 8'h0d, 32'h0000_0000, 1'b1);
    bus(1'b1, 8'h0c, 32'h0000_0055, 1'b1);
    bus(1'b0, 8'h10, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_ram;
    put_block(9'd5, 8'h80, 34);
    for (int k = 0; k < 34; k++) begin
      rd(8'h0c, {24'h00_0000, 8'ha5 ^ k[7:0]});
    end
    rd(8'h0c, 32'h0000_0084);
    @(posedge i_clk);
    i_irq_event <= 1'b1;
    @(posedge i_clk);
    i_irq_event <= 1'b0;
    rd(8'h0c, 32'h0000_00a5);
    bus(1'b1, 8'h10, 32'h0000_0000, 1'b0);
    rd(8'h0c, 32'h0000_00a5);
    rd(8'h0c, 32'h0000_00a4);
  endtask
  task automatic t_status;
    logic [8:0] nums [16];
    nums = '{9'd1, 9'd13, 9'd14, 9'd136, 9'd137, 9'd149, 9'd150, 9'd272,
      9'd1, 9'd60, 9'd61, 9'd130, 9'd131, 9'd190, 9'd191, 9'd284};
    for (int i = 0; i < 16; i++) begin
      i_method <= {i > 7, i > 11, 1'b0};
      put_block(nums[i], {6'b110001, i[1:0]}, 0);
      rd(8'h08, {24'h00_0000, 5'b00101, i[2:0] ^ 3'b001});
      rd(8'h1c, {29'h0000_0000, 1'b1, i[1:0]});
    end
  endtask
  task automatic t_fields;
    i_method <= 3'b001;
    put_block(9'd2, 8'hb8, 0);
    rd(8'h08, 32'h0000_00f0);
    i_method <= 3'b000;
    put_block(9'd2, 8'hb8, 0);
    rd(8'h08, 32'h0000_0070);
    bus(1'b1, 8'h10, 32'h0000_0002, 1'b0);
    put_block(9'd2, 8'h78, 0);
    rd(8'h08, 32'h0000_0048);
    bus(1'b1, 8'h10, 32'h0000_0000, 1'b0);
    put_block(9'd2, 8'h40, 0);
    rd(8'h08, 32'h0000_0048);
  endtask
  task automatic t_gate;
    i_edge_in_gate <= 1'b1;
    bus(1'b1, 8'h24, 32'h0000_000e, 1'b0);
    wait_out();
    check({31'h0000_0000, o_gate_sel}, 33'h0_0000_0003);
    check({32'h0000_0000, o_use_inside_const}, 33'h0_0000_0001);
    put_block(9'd2, 8'h80, 0);
    wait_out();
    check({31'h0000_0000, o_gate_sel}, 33'h0_0000_0002);
    bus(1'b1, 8'h24, 32'h0000_0000, 1'b0);
    wait_out();
    check({32'h0000_0000, o_use_inside_const}, 33'h0_0000_0000);
  endtask
  // a block start while the enable is low must leave status and code alone
  task automatic t_freeze;
    @(posedge i_clk);
    i_ce <= 1'b0;
    put_block(9'd1, 8'hff, 0);
    i_ce <= 1'b1;
    rd(8'h08, 32'h0000_0020);
    rd(8'h1c, 32'h0000_0000);
  endtask
  task automatic t_phase;
    logic [7:0] val [4];
    logic [6:0] exp [4];
    // last entry is full lead less the largest legal delays
    val = '{8'h40, 8'h24, 8'h0b, 8'h64};
    exp = '{7'h19, 7'h68, 7'h78, 7'h01};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h20, {24'h00_0000, val[i]}, 1'b0);
      wait_out();
      check({26'h000_0000, o_phase_offset}, {26'h000_0000, exp[i]});
    end
  endtask
  // main sequence
  initial begin
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_block_start = 1'b0;
    i_block = '0;
    i_byte_valid = 1'b0;
    i_byte = 8'h00;
    i_irq_event = 1'b0;
    i_method = 3'b000;
    i_edge_in_gate = 1'b0;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_refuse();
    t_ram();
    t_status();
    t_fields();
    t_gate();
    t_freeze();
    t_phase();
    stop_test();
  end
endmodule // test_fmrx_rx_buffer
`default_nettype wire
